// File: src/mae_defs.svh
// register offsets, field layouts and reset values of the error bank
`ifndef MAE_DEFS_SVH
`define MAE_DEFS_SVH

// ==========================================================
// byte offsets
`define MAE_OFF_MADDR   12'h0f4
`define MAE_OFF_MADDRHI 12'h0f8
`define MAE_OFF_MDATA   12'h0fc
`define MAE_OFF_CAPHDR  12'h100
`define MAE_OFF_USTAT   12'h104
`define MAE_OFF_UMASK   12'h108
`define MAE_OFF_USEV    12'h10c
`define MAE_OFF_CSTAT   12'h110
`define MAE_OFF_CMASK   12'h114
`define MAE_OFF_CAPCTL  12'h118
`define MAE_OFF_HLOG0   12'h11c
`define MAE_OFF_HLOG1   12'h120
`define MAE_OFF_HLOG2   12'h124

// ==========================================================
// fixed fields, implemented bit sets, severity reset value and control bit positions
`define MAE_CAP_ID      16'h0001
`define MAE_CAP_VER     4'h1
`define MAE_CAP_NEXT    12'h150
`define MAE_UNC_VALID   32'h001f_f011
`define MAE_COR_VALID   32'h0000_11c1
`define MAE_USEV_RST    32'h0006_2011
`define MAE_CTL_GENCAP  5
`define MAE_CTL_GENEN   6
`define MAE_CTL_CHKCAP  7
`define MAE_CTL_CHKEN   8

`endif

// File: src/mae_pkg.sv
// types of the interrupt message and error reporting register bank
`default_nettype none

package mae_pkg;

    // ==========================================================
    // whole state of the bank, registered as one word
    typedef struct packed {
        logic        hrst_s1;
        logic        hrst_s2;
        logic [29:0] maddr;
        logic [31:0] maddr_hi;
        logic [15:0] mdata;
        logic [31:0] ustat;
        logic [31:0] umask;
        logic [31:0] usev;
        logic [31:0] cstat;
        logic [31:0] cmask;
        logic [4:0]  fep;
        logic        ecrc_gen;
        logic        ecrc_chk;
        logic [95:0] hlog;
        logic [31:0] rdata;
        logic        irq_d;
        logic        msi_wr;
        logic        intx;
        logic        rep_fat;
        logic        rep_nf;
        logic        rep_cor;
    } mae_state_t;

endpackage

`default_nettype wire

// File: src/mae_regs.sv
// interrupt message address/data and error reporting register bank
`include "mae_defs.svh"
`default_nettype none

module mae_regs
    import mae_pkg::*;
(
    // clock and resets
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        hot_resetn_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // error events from the link logic
    input  wire logic [31:0] unc_err_i,
    input  wire logic [31:0] cor_err_i,
    input  wire logic [95:0] hdr_i,
    // error reporting
    output logic             rep_fatal_o,
    output logic             rep_nonfatal_o,
    output logic             rep_cor_o,
    output logic             ecrc_gen_en_o,
    output logic             ecrc_chk_en_o,
    // interrupt delivery
    input  wire logic        msi_en_i,
    input  wire logic        intx_i,
    output logic             msi_wr_o,
    output logic      [63:0] msi_addr_o,
    output logic      [31:0] msi_data_o,
    output logic             intx_o
);

    // ==========================================================
    // helpers
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a >= `MAE_OFF_MADDR) && (a <= `MAE_OFF_HLOG2)
                 && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [4:0] low_idx(input logic [31:0] v);
        low_idx = 5'd0;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                low_idx = 5'(i);
            end
        end
    endfunction

    function automatic logic [31:0] rd_word(
        input logic [11:0] a,
        input mae_state_t  s
    );
        rd_word = 32'h0000_0000;
        case (a)
            `MAE_OFF_MADDR:   rd_word = {s.maddr, 2'b00};
            `MAE_OFF_MADDRHI: rd_word = s.maddr_hi;
            `MAE_OFF_MDATA:   rd_word = {16'h0000, s.mdata};
            `MAE_OFF_CAPHDR:  rd_word = {`MAE_CAP_NEXT, `MAE_CAP_VER,
                                         `MAE_CAP_ID};
            `MAE_OFF_USTAT:   rd_word = s.ustat;
            `MAE_OFF_UMASK:   rd_word = s.umask;
            `MAE_OFF_USEV:    rd_word = s.usev;
            `MAE_OFF_CSTAT:   rd_word = s.cstat;
            `MAE_OFF_CMASK:   rd_word = s.cmask;
            `MAE_OFF_CAPCTL:  rd_word = {23'h00_0000, s.ecrc_chk, 1'b1,
                                         s.ecrc_gen, 1'b1, s.fep};
            `MAE_OFF_HLOG0:   rd_word = s.hlog[95:64];
            `MAE_OFF_HLOG1:   rd_word = s.hlog[63:32];
            `MAE_OFF_HLOG2:   rd_word = s.hlog[31:0];
            default:          rd_word = 32'h0000_0000;
        endcase
    endfunction

    // ==========================================================
    // state
    localparam mae_state_t ST_RST = '{
        usev:    `MAE_USEV_RST,
        default: '0
    };

    mae_state_t s_r;
    mae_state_t s_nxt;

    logic        acc;
    logic        wr;
    logic [31:0] unew;
    logic [31:0] unm;
    logic [31:0] cnew;
    logic        fep_busy;
    logic        hot;

    assign acc      = psel_i & penable_i;
    assign wr       = acc & pwrite_i & mapped(paddr_i);
    assign unew     = unc_err_i & `MAE_UNC_VALID;
    assign unm      = unew & ~s_r.umask;
    assign cnew     = cor_err_i & `MAE_COR_VALID;
    assign fep_busy = s_r.ustat[s_r.fep];
    assign hot      = ~s_r.hrst_s2;

    // ==========================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.hrst_s1 = hot_resetn_i;
        s_nxt.hrst_s2 = s_r.hrst_s1;

        // read data is latched in the setup phase, so it is a flop
        if (psel_i && !penable_i && !pwrite_i) begin
            s_nxt.rdata = rd_word(paddr_i, s_r);
        end

        if (wr) begin
            case (paddr_i)
                `MAE_OFF_MADDR: begin
                    s_nxt.maddr = pwdata_i[31:2];
                end
                `MAE_OFF_MADDRHI: begin
                    s_nxt.maddr_hi = pwdata_i;
                end
                `MAE_OFF_MDATA: begin
                    s_nxt.mdata = pwdata_i[15:0];
                end
                `MAE_OFF_UMASK: begin
                    s_nxt.umask = pwdata_i & `MAE_UNC_VALID;
                end
                `MAE_OFF_USEV: begin
                    s_nxt.usev = pwdata_i & `MAE_UNC_VALID;
                end
                `MAE_OFF_CMASK: begin
                    s_nxt.cmask = pwdata_i & `MAE_COR_VALID;
                end
                `MAE_OFF_CAPCTL: begin
                    s_nxt.ecrc_gen = pwdata_i[`MAE_CTL_GENEN];
                    s_nxt.ecrc_chk = pwdata_i[`MAE_CTL_CHKEN];
                end
                default: begin
                end
            endcase
        end

        // the event wins over a clearing write in the same cycle
        s_nxt.ustat = s_r.ustat;
        if (wr && paddr_i == `MAE_OFF_USTAT) begin
            s_nxt.ustat = s_r.ustat & ~pwdata_i;
        end
        s_nxt.ustat = s_nxt.ustat | unew;

        s_nxt.cstat = s_r.cstat;
        if (wr && paddr_i == `MAE_OFF_CSTAT) begin
            s_nxt.cstat = s_r.cstat & ~pwdata_i;
        end
        s_nxt.cstat = s_nxt.cstat | cnew;

        // a logged error stays until software clears its flag
        if (|unm && !fep_busy) begin
            s_nxt.fep  = low_idx(unm);
            s_nxt.hlog = hdr_i;
        end

        s_nxt.rep_fat = |(unm & s_r.usev);
        s_nxt.rep_nf  = |(unm & ~s_r.usev);
        s_nxt.rep_cor = |(cnew & ~s_r.cmask);

        // legacy pin is muted while messages are enabled
        s_nxt.irq_d  = intx_i;
        s_nxt.msi_wr = msi_en_i & intx_i & ~s_r.irq_d;
        s_nxt.intx   = ~msi_en_i & intx_i;

        // hot reset touches only the non-sticky fields
        if (hot) begin
            s_nxt.maddr    = '0;
            s_nxt.maddr_hi = '0;
            s_nxt.mdata    = '0;
            s_nxt.rdata    = '0;
            s_nxt.irq_d    = 1'b0;
            s_nxt.msi_wr   = 1'b0;
            s_nxt.intx     = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign prdata_o       = s_r.rdata;
    assign pready_o       = 1'b1;
    assign pslverr_o      = acc & ~mapped(paddr_i);
    assign rep_fatal_o    = s_r.rep_fat;
    assign rep_nonfatal_o = s_r.rep_nf;
    assign rep_cor_o      = s_r.rep_cor;
    assign ecrc_gen_en_o  = s_r.ecrc_gen;
    assign ecrc_chk_en_o  = s_r.ecrc_chk;
    assign msi_wr_o       = s_r.msi_wr;
    assign msi_addr_o     = {s_r.maddr_hi, s_r.maddr, 2'b00};
    assign msi_data_o     = {16'h0000, s_r.mdata};
    assign intx_o         = s_r.intx;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    sequence rd_at(logic [11:0] a);
        psel_i && !penable_i && !pwrite_i && paddr_i == a && !hot;
    endsequence

    AST_ADDR_LOW: assert property (
        rd_at(`MAE_OFF_MADDR) |=> prdata_o[1:0] == 2'b00)
        else $error("message address low bits not zero");

    AST_UPPER_WR: assert property (
        wr && paddr_i == `MAE_OFF_MADDRHI && !hot
        |=> msi_addr_o[63:32] == $past(pwdata_i))
        else $error("upper address not written");

    AST_DATA_HI: assert property (
        rd_at(`MAE_OFF_MDATA) |=> prdata_o[31:16] == 16'h0000)
        else $error("message data upper half not zero");

    AST_CAP_ID: assert property (
        rd_at(`MAE_OFF_CAPHDR) |=> prdata_o[15:0] == 16'h0001)
        else $error("capability id wrong");

    AST_CAP_VER: assert property (
        rd_at(`MAE_OFF_CAPHDR) |=> prdata_o[19:16] == 4'h1)
        else $error("capability version wrong");

    AST_CAP_NEXT: assert property (
        rd_at(`MAE_OFF_CAPHDR) |=> prdata_o[31:20] == 12'h150)
        else $error("next capability offset wrong");

    AST_USTAT_W1C: assert property (
        wr && paddr_i == `MAE_OFF_USTAT && pwdata_i[0] && !unc_err_i[0]
        |=> !s_r.ustat[0])
        else $error("uncorrectable flag not cleared");

    AST_USTAT_RSV: assert property (
        (s_r.ustat & ~32'h001f_f011) == 32'h0000_0000)
        else $error("reserved uncorrectable flag set");

    AST_MASKED: assert property (
        unm == 32'h0000_0000 |=> !rep_fatal_o && !rep_nonfatal_o)
        else $error("masked error reported");

    AST_SEV_FATAL: assert property (
        unc_err_i[13] && !s_r.umask[13] && s_r.usev[13]
        |=> rep_fatal_o)
        else $error("fatal error not reported");

    AST_COR_SET: assert property (
        cor_err_i[6] |=> s_r.cstat[6] ##1 s_r.cstat[6] || $past(wr))
        else $error("correctable flag not set");

    AST_CMASK_RSV: assert property (
        (s_r.cmask & ~32'h0000_11c1) == 32'h0000_0000)
        else $error("reserved correctable mask set");

    AST_CTL_CAP: assert property (
        rd_at(`MAE_OFF_CAPCTL) |=> prdata_o[5] && prdata_o[7])
        else $error("ecrc capable bits not one");

    AST_HLOG: assert property (
        |unm && !fep_busy |=> s_r.hlog == $past(hdr_i))
        else $error("header not logged");

    AST_MSI: assert property (
        msi_en_i && intx_i && !s_r.irq_d && !hot
        |=> msi_wr_o && !intx_o)
        else $error("message not sent");

    AST_FEP: assert property (
        unm[4] && unm[0] == 1'b0 && unm[3:1] == 3'b000 && !fep_busy
        |=> s_r.fep == 5'd4)
        else $error("first error pointer wrong");

    AST_STICKY: assert property (
        hot && !wr && unew == 32'h0000_0000 |=> $stable(s_r.ustat))
        else $error("sticky flags lost in hot reset");

    AST_UMASK_RSV: assert property (
        (s_r.umask & ~32'h001f_f011) == 32'h0000_0000)
        else $error("reserved uncorrectable mask set");

    AST_USEV_RSV: assert property (
        (s_r.usev & ~32'h001f_f011) == 32'h0000_0000)
        else $error("reserved severity bit set");

    AST_CSTAT_RSV: assert property (
        (s_r.cstat & ~32'h0000_11c1) == 32'h0000_0000)
        else $error("reserved correctable flag set");

    AST_CSTAT_W1C: assert property (
        wr && paddr_i == `MAE_OFF_CSTAT && pwdata_i[12] && !cor_err_i[12]
        |=> !s_r.cstat[12])
        else $error("correctable flag not cleared");

    AST_SEV_NONFATAL: assert property (
        unc_err_i[12] && !s_r.umask[12] && !s_r.usev[12]
        |=> rep_nonfatal_o && !rep_fatal_o)
        else $error("non-fatal error not reported");

    AST_COR_REP: assert property (
        cor_err_i[0] && !s_r.cmask[0] |=> rep_cor_o)
        else $error("correctable error not reported");

    AST_COR_MASKED: assert property (
        (cnew & ~s_r.cmask) == 32'h0000_0000 |=> !rep_cor_o)
        else $error("masked correctable error reported");

    AST_ECRC_EN: assert property (
        wr && paddr_i == `MAE_OFF_CAPCTL
        |=> ecrc_gen_en_o == $past(pwdata_i[`MAE_CTL_GENEN])
            && ecrc_chk_en_o == $past(pwdata_i[`MAE_CTL_CHKEN]))
        else $error("ecrc enables not written");

    AST_MADDR_WR: assert property (
        wr && paddr_i == `MAE_OFF_MADDR && !hot
        |=> msi_addr_o[31:2] == $past(pwdata_i[31:2]))
        else $error("message address not written");

    AST_MDATA_WR: assert property (
        wr && paddr_i == `MAE_OFF_MDATA && !hot
        |=> msi_data_o == {16'h0000, $past(pwdata_i[15:0])})
        else $error("message data not written");

    AST_LEGACY: assert property (
        !msi_en_i && !hot
        |=> intx_o == $past(intx_i) && !msi_wr_o)
        else $error("legacy interrupt not passed");

    AST_MSI_MUTE: assert property (
        msi_en_i |=> !intx_o)
        else $error("legacy pin active with messages enabled");

    AST_HOT_CLR: assert property (
        hot |=> msi_addr_o == 64'h0000_0000_0000_0000)
        else $error("message address kept in hot reset");

    AST_LOG_HOLD: assert property (
        fep_busy |=> $stable(s_r.hlog) && $stable(s_r.fep))
        else $error("log overwritten while pending");

    COV_MSI: cover property (msi_wr_o);
    COV_FATAL: cover property (rep_fatal_o);
    COV_CLR_SET: cover property (
        wr && paddr_i == `MAE_OFF_USTAT && |(pwdata_i & unew));
    COV_SLVERR: cover property (pslverr_o);
    COV_HOT: cover property (hot ##1 !hot);

endmodule

`default_nettype wire

// File: bench/mae_host.sv
// apb master model standing in for the configuration host
`default_nettype none
module mae_host (
    // bus answer
    input  wire logic        clk_i,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    // bus request
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic      [11:0] paddr_o,
    output logic      [31:0] pwdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = '0;
        pwdata_o = '0;
    end
    // ==========================================================
    // one transfer; request held until pready seen at an edge, for at most 16 edges
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic err, output logic ok);
        ok = 1'b0;
        q = '0;
        err = 1'b0;
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge clk_i);
            if (pready_i === 1'b1) begin
                ok = 1'b1;
                q = prdata_i;
                err = pslverr_i;
            end
        end
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the message and error reporting bank
`include "mae_defs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mae_pkg::*;
    logic mclk = 0, rst_n = 0, hot_n = 1, psel, pen, pwr, prdy, perr;
    logic msi_en = 0, intx = 0, r_fat, r_nf, r_cor, gen_en, chk_en;
    logic msi_wr, intx_out, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, unc = '0, cor = '0, mdata;
    logic [95:0] hdr = '0;
    logic [63:0] maddr;
    int miscompares = 0;
    int cmp_count = 0;
    always #20 mclk = ~mclk;
    mae_regs mae_regs_inst (.mclk_i(mclk), .resetn_i(rst_n),
        .hot_resetn_i(hot_n), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr),
        .unc_err_i(unc), .cor_err_i(cor), .hdr_i(hdr),
        .rep_fatal_o(r_fat), .rep_nonfatal_o(r_nf), .rep_cor_o(r_cor),
        .ecrc_gen_en_o(gen_en), .ecrc_chk_en_o(chk_en),
        .msi_en_i(msi_en), .intx_i(intx), .msi_wr_o(msi_wr),
        .msi_addr_o(maddr), .msi_data_o(mdata), .intx_o(intx_out));
    mae_host mae_host_inst (.clk_i(mclk), .prdata_i(prdata),
        .pready_i(prdy), .pslverr_i(perr), .psel_o(psel),
        .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr),
        .pwdata_o(pwdata));
    // ==========================================================
    // shared checking and bus tasks
    task automatic check(string nm, logic [95:0] seen, logic [95:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic bus(logic w, logic [11:0] a, logic [31:0] d,
                       output logic [31:0] q);
        logic ok;
        mae_host_inst.xfer(w, a, d, q, last_err, ok);
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] pready expected 1 seen 0");
            report_and_stop();
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, '0, q);
        check($sformatf("reg %h", a), 96'(q), 96'(exp));
    endtask
    // event pulse of one cycle; outputs settled on return
    task automatic ev(logic [31:0] u, logic [31:0] c, logic [95:0] h);
        @(posedge mclk);
        unc <= u;
        cor <= c;
        hdr <= h;
        @(posedge mclk);
        unc <= '0;
        cor <= '0;
        #1;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset;
        logic [31:0] rv [13] = '{0, 0, 0, 32'h1501_0001, 0, 0,
            32'h0006_2011, 0, 0, 32'h0000_00a0, 0, 0, 0};
        for (int i = 0; i < 13; i++) begin
            rd(`MAE_OFF_MADDR + 12'(4 * i), rv[i]);
        end
        rd(12'h128, '0);
        check("slverr", 96'(last_err), 96'(1));
        $display("t_reset done");
    endtask
    task automatic t_rw;
        logic [31:0] rv [10] = '{32'hffff_fffc, 32'hffff_ffff,
            32'h0000_ffff, 32'h1501_0001, 0, 32'h001f_f011,
            32'h001f_f011, 0, 32'h0000_11c1, 32'h0000_01e0};
        for (int i = 0; i < 10; i++) begin
            wr(`MAE_OFF_MADDR + 12'(4 * i), 32'hffff_ffff);
        end
        for (int i = 0; i < 10; i++) begin
            rd(`MAE_OFF_MADDR + 12'(4 * i), rv[i]);
        end
        check("msi addr", 96'(maddr), 96'(64'hffff_ffff_ffff_fffc));
        check("ecrc en", 96'({gen_en, chk_en}), 96'(2'b11));
        wr(`MAE_OFF_UMASK, '0);
        wr(`MAE_OFF_CMASK, '0);
        wr(`MAE_OFF_USEV, 32'h0006_2011);
        $display("t_rw done");
    endtask
    task automatic t_err;
        ev(32'h0020_2012, '0, 96'h0011_2233_4455_6677_8899_aabb);
        check("fatal rep", 96'({r_fat, r_nf}), 96'(2'b10));
        rd(`MAE_OFF_USTAT, 32'h0000_2010);
        rd(`MAE_OFF_CAPCTL, 32'h0000_01e4);
        rd(`MAE_OFF_HLOG0, 32'h0011_2233);
        rd(`MAE_OFF_HLOG1, 32'h4455_6677);
        rd(`MAE_OFF_HLOG2, 32'h8899_aabb);
        ev(32'h0000_1000, '0, 96'h1);
        check("nonfatal rep", 96'({r_fat, r_nf}), 96'(2'b01));
        rd(`MAE_OFF_HLOG2, 32'h8899_aabb);
        wr(`MAE_OFF_UMASK, 32'h0000_4000);
        ev(32'h0000_4000, '0, '0);
        check("masked rep", 96'({r_fat, r_nf}), 96'(0));
        wr(`MAE_OFF_USTAT, 32'h0000_0010);
        rd(`MAE_OFF_USTAT, 32'h0000_7000);
        ev('0, 32'hffff_ffff, '0);
        check("cor rep", 96'(r_cor), 96'(1));
        rd(`MAE_OFF_CSTAT, 32'h0000_11c1);
        wr(`MAE_OFF_CSTAT, 32'hffff_ffff);
        rd(`MAE_OFF_CSTAT, '0);
        $display("t_err done");
    endtask
    task automatic t_hot;
        @(posedge mclk);
        hot_n <= 1'b0;
        repeat (4) @(posedge mclk);
        hot_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(`MAE_OFF_MADDRHI, '0);
        rd(`MAE_OFF_MDATA, '0);
        rd(`MAE_OFF_USEV, 32'h0006_2011);
        rd(`MAE_OFF_USTAT, 32'h0000_7000);
        rd(`MAE_OFF_UMASK, 32'h0000_4000);
        rd(`MAE_OFF_CAPCTL, 32'h0000_01e4);
        rd(`MAE_OFF_HLOG0, 32'h0011_2233);
        $display("t_hot done");
    endtask
    task automatic t_msi;
        wr(`MAE_OFF_MADDR, 32'h1234_5677);
        wr(`MAE_OFF_MDATA, 32'hbeef_cafe);
        // the write lands at the edge the bus task returns on
        #1;
        check("msi addr", 96'(maddr), 96'(64'h0000_0000_1234_5674));
        check("msi data", 96'(mdata), 96'(32'h0000_cafe));
        @(posedge mclk);
        msi_en <= 1'b1;
        intx <= 1'b1;
        @(posedge mclk);
        #1;
        check("msi pulse", 96'({msi_wr, intx_out}), 96'(2'b10));
        @(posedge mclk);
        msi_en <= 1'b0;
        #1;
        check("msi end", 96'({msi_wr, intx_out}), 96'(0));
        @(posedge mclk);
        #1;
        check("legacy", 96'({msi_wr, intx_out}), 96'(2'b01));
        $display("t_msi done");
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_rw();
        t_err();
        t_hot();
        t_msi();
        report_and_stop();
    end
endmodule
`default_nettype wire
